//--- tppd_pkg.sv
`default_nettype none
package tppd_pkg;

   // phases and serial frame
   localparam int          PHASES      = 3;
   localparam int          CMD_W       = 8;
   localparam int          OP_MSB      = 7;
   localparam int          OP_LSB      = 5;
   localparam int          ARG_W       = 5;

   // command opcodes, top three bits of a frame
   localparam logic [2:0]  OP_READ_SEL    = 3'h0;
   localparam logic [2:0]  OP_MASK_FIRST  = 3'h1;
   localparam logic [2:0]  OP_MASK_SECOND = 3'h2;
   localparam logic [2:0]  OP_MODE        = 3'h3;
   localparam logic [2:0]  OP_DEAD_TIME   = 3'h4;
   localparam logic [2:0]  OP_CLEAR_IRQ   = 3'h5;

   // read pages selected by the low bits of a read-select frame
   localparam logic [1:0]  PAGE_FAULTS = 2'h0;
   localparam logic [1:0]  PAGE_MASKS  = 2'h1;
   localparam logic [1:0]  PAGE_CONFIG = 2'h2;
   localparam logic [1:0]  PAGE_BOOT   = 2'h3;
   localparam logic [1:0]  PAGE_RESET  = 2'h0;

   // faults, masks (1 = masked), mode bits
   localparam int          FAULT_W          = 8;
   localparam int          MASK_W           = 4;
   localparam logic [3:0]  MASK_RESET       = 4'h0;
   localparam int          MODE_W           = 2;
   localparam int          MODE_DT_OFF_BIT  = 0;
   localparam int          MODE_ILK_OFF_BIT = 1;
   localparam logic [1:0]  MODE_RESET       = 2'h0;
   localparam logic [4:0]  DEAD_TIME_RESET  = 5'h04;

   // input synchroniser map
   localparam int          SYNC_W      = 21;
   localparam int          S_EN1       = 0;
   localparam int          S_EN2       = 1;
   localparam int          S_HIGH_N    = 2;
   localparam int          S_LOW       = 5;
   localparam int          S_ABOVE     = 8;
   localparam int          S_FAULT     = 11;
   localparam int          S_CS_N      = 19;
   localparam int          S_RX_TOG    = 20;
   localparam logic [20:0] SYNC_RESET  = 21'h08001c;

   // timing
   localparam int          SYS_CLK_MHZ  = 250;
   localparam int          DT_STEP_NS   = 64;
   localparam int          DT_STEP_INT  =
      (DT_STEP_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int          DT_CNT_W     = 9;
   localparam logic [8:0]  DT_STEP_CYC  = DT_STEP_INT[8:0];
   localparam int          RST_DONE_NS  = 77;
   localparam int          RST_DONE_CYC =
      (RST_DONE_NS * SYS_CLK_MHZ / 1000 < 1) ? 1 :
      RST_DONE_NS * SYS_CLK_MHZ / 1000;
   localparam int          SCLK_TYP_KHZ = 3000;
   localparam int          SCLK_MAX_KHZ = 5000;

endpackage
`default_nettype wire

//--- tppd_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module tppd_serial_port
   import tppd_pkg::*;
(
   input  wire logic             i_sclk,
   input  wire logic             i_rst_n,
   input  wire logic             i_cs_n,
   input  wire logic             i_sdi,
   input  wire logic [CMD_W-1:0] i_tx_word,
   output logic                  o_sdo,
   output logic                  o_sdo_oe,
   output logic [CMD_W-1:0]      o_rx_word,
   output logic                  o_rx_toggle
);

   logic             frame_rst_n;
   logic [2:0]       rx_cnt;
   logic [CMD_W-2:0] rx_shift;
   logic [2:0]       tx_idx;

   // sclk stops outside frames, so chip select itself ends the frame
   assign frame_rst_n = i_rst_n & ~i_cs_n; // see RULE12 see RULE15

   always_ff @(negedge i_sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         rx_cnt   <= 3'h0;
         rx_shift <= '0;
      end else begin
         rx_cnt   <= rx_cnt + 3'h1;
         rx_shift <= {rx_shift[CMD_W-3:0], i_sdi}; // see RULE13
      end
   end

   // word and toggle survive chip select so the system side can read them
   always_ff @(negedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rx_word   <= '0;
         o_rx_toggle <= 1'b0;
      end else if (!i_cs_n && rx_cnt == 3'h7) begin
         o_rx_word   <= {rx_shift, i_sdi}; // see RULE13
         o_rx_toggle <= ~o_rx_toggle;
      end
   end

   // idle-low clock: first rising edge must keep the msb; see RULE14
   always_ff @(posedge i_sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         tx_idx <= 3'h0;
      end else begin
         tx_idx <= rx_cnt; // see RULE17
      end
   end

   assign o_sdo    = frame_rst_n & i_tx_word[3'h7 - tx_idx]; // see RULE17
   assign o_sdo_oe = frame_rst_n; // see RULE17

endmodule // tppd_serial_port
`default_nettype wire

//--- tppd_predriver_top.sv
// Notes on behaviour
// RULE1 - a gate may turn on only while both enables are high, ANDed.
// RULE2 - either enable low forces all gates off; serial logic keeps running.
// RULE3 - enables force gates off asynchronously, without waiting for a clock.
// RULE4 - host pulses each low side on before high side after enabling.
// RULE5 - reset low: low-power, outputs disabled, gates weakly pulled low.
// RULE6 - internal logic is reset within 77 ns of reset falling.
// RULE7 - high-side commands are active low, default inactive via pull-up.
// RULE8 - low-side commands are active high, default inactive via pull-down.
// RULE9 - phase status low while its source is below half the load supply.
// RULE10 - unmasked fault raises interrupt, held until clear-interrupt command.
// RULE11 - two serial mask registers gate each fault off the interrupt.
// RULE12 - active-low chip select frames commands, defaults inactive.
// RULE13 - serial data sampled on falling clock edges, msb first.
// RULE14 - serial clock typically 3 MHz, at most 5 MHz, defaults low.
// RULE15 - before power-on threshold: logic reset, drivers floating, serial ignored.
// RULE16 - dead-time and interlock keep phase drivers apart; both can be overridden.
// RULE17 - serial output floats until select low, changes on rising edges.
// RULE18 - during any reset interrupt is low and faults, masks default.
`timescale 1ns/1ps
`default_nettype none
module tppd_predriver_top
   import tppd_pkg::*;
(
   input  wire logic               i_sys_clk,
   input  wire logic               i_nrst,
   input  wire logic               i_por_n,
   input  wire logic               i_drive_enable_first,
   input  wire logic               i_drive_enable_second,
   input  wire logic               i_phase_a_high_cmd_n,
   input  wire logic               i_phase_b_high_cmd_n,
   input  wire logic               i_phase_c_high_cmd_n,
   input  wire logic               i_phase_a_low_cmd,
   input  wire logic               i_phase_b_low_cmd,
   input  wire logic               i_phase_c_low_cmd,
   input  wire logic               i_phase_a_above_half,
   input  wire logic               i_phase_b_above_half,
   input  wire logic               i_phase_c_above_half,
   input  wire logic [FAULT_W-1:0] i_fault_event,
   input  wire logic               i_spi_sclk,
   input  wire logic               i_spi_cs_n,
   input  wire logic               i_spi_sdi,
   output logic                    o_phase_a_high_gate,
   output logic                    o_phase_b_high_gate,
   output logic                    o_phase_c_high_gate,
   output logic                    o_phase_a_low_gate,
   output logic                    o_phase_b_low_gate,
   output logic                    o_phase_c_low_gate,
   output logic                    o_gate_oe,
   output logic                    o_gate_weak_pull,
   output logic                    o_phase_a_level_out,
   output logic                    o_phase_b_level_out,
   output logic                    o_phase_c_level_out,
   output logic                    o_fault_irq,
   output logic [FAULT_W-1:0]      o_fault_status,
   output logic                    o_spi_sdo,
   output logic                    o_spi_sdo_oe
);

   logic               rst_n;
   logic               drive_allowed;
   logic [SYNC_W-1:0]  async_in;
   logic [SYNC_W-1:0]  sync_meta;
   logic [SYNC_W-1:0]  sync_q;
   logic [CMD_W-1:0]   rx_word;
   logic               rx_toggle;
   logic               rx_seen;
   logic               new_cmd;
   logic [2:0]         cmd_op;
   logic [ARG_W-1:0]   cmd_arg;
   logic               clear_irq;
   logic [MASK_W-1:0]  fault_mask_reg_first;
   logic [MASK_W-1:0]  fault_mask_reg_second;
   logic [FAULT_W-1:0] mask_all;
   logic [MODE_W-1:0]  mode;
   logic [ARG_W-1:0]   dead_time;
   logic [1:0]         read_page;
   logic [FAULT_W-1:0] fault_latch;
   logic [CMD_W-1:0]   tx_word;
   logic [CMD_W-1:0]   next_tx_word;
   logic               en_sync;
   logic               dt_off;
   logic               ilk_off;
   logic [PHASES-1:0]  req_high;
   logic [PHASES-1:0]  req_low;
   logic [PHASES-1:0]  high_on;
   logic [PHASES-1:0]  low_on;
   logic [PHASES-1:0]  boot_ready;
   logic [PHASES-1:0]  level_q;
   logic [DT_CNT_W-1:0] dead_load;

   // power-on and pin reset share one asynchronous path, no clock needed
   assign rst_n = i_nrst & i_por_n; // see RULE6 see RULE15

   // raw pins on purpose: turn-off must not wait for the synchroniser
   assign drive_allowed = i_drive_enable_first & i_drive_enable_second &
                          rst_n; // see RULE1 see RULE3 see RULE5

   assign async_in = {rx_toggle,
                      i_spi_cs_n,
                      i_fault_event,
                      i_phase_c_above_half,
                      i_phase_b_above_half,
                      i_phase_a_above_half,
                      i_phase_c_low_cmd,
                      i_phase_b_low_cmd,
                      i_phase_a_low_cmd,
                      i_phase_c_high_cmd_n,
                      i_phase_b_high_cmd_n,
                      i_phase_a_high_cmd_n,
                      i_drive_enable_second,
                      i_drive_enable_first};

   // two-stage synchroniser; reset values are the inactive pin levels
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_meta <= SYNC_RESET; // see RULE7 see RULE8 see RULE12
         sync_q    <= SYNC_RESET;
      end else begin
         sync_meta <= async_in;
         sync_q    <= sync_meta;
      end
   end

   tppd_serial_port u_serial (
      .i_sclk      (i_spi_sclk),
      .i_rst_n     (rst_n),
      .i_cs_n      (i_spi_cs_n),
      .i_sdi       (i_spi_sdi),
      .i_tx_word   (tx_word),
      .o_sdo       (o_spi_sdo),
      .o_sdo_oe    (o_spi_sdo_oe),
      .o_rx_word   (rx_word),
      .o_rx_toggle (rx_toggle)
   );

   // a frame toggles once; the word holds until the next frame's eighth falling edge
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_seen <= 1'b0;
      end else begin
         rx_seen <= sync_q[S_RX_TOG];
      end
   end

   assign new_cmd   = sync_q[S_RX_TOG] ^ rx_seen;
   assign cmd_op    = rx_word[OP_MSB:OP_LSB];
   assign cmd_arg   = rx_word[ARG_W-1:0];
   assign clear_irq = new_cmd && cmd_op == OP_CLEAR_IRQ;

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_mask_reg_first  <= MASK_RESET; // see RULE18
         fault_mask_reg_second <= MASK_RESET;
      end else if (new_cmd && cmd_op == OP_MASK_FIRST) begin
         fault_mask_reg_first  <= cmd_arg[MASK_W-1:0]; // see RULE11
      end else if (new_cmd && cmd_op == OP_MASK_SECOND) begin
         fault_mask_reg_second <= cmd_arg[MASK_W-1:0]; // see RULE11
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= MODE_RESET;
      end else if (new_cmd && cmd_op == OP_MODE) begin
         mode <= cmd_arg[MODE_W-1:0]; // see RULE16
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dead_time <= DEAD_TIME_RESET;
      end else if (new_cmd && cmd_op == OP_DEAD_TIME) begin
         dead_time <= cmd_arg; // see RULE16
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         read_page <= PAGE_RESET;
      end else if (new_cmd && cmd_op == OP_READ_SEL) begin
         read_page <= cmd_arg[1:0];
      end
   end

   assign mask_all = {fault_mask_reg_second, fault_mask_reg_first};

   // a new event in the clearing cycle wins over the clear
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_latch <= '0; // see RULE18
      end else begin
         fault_latch <= (fault_latch & ~{FAULT_W{clear_irq}}) |
                        sync_q[S_FAULT +: FAULT_W];
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_fault_irq <= 1'b0; // see RULE18
      end else begin
         o_fault_irq <= (o_fault_irq & ~clear_irq) |
                        (|(sync_q[S_FAULT +: FAULT_W] &
                           ~mask_all)); // see RULE10 see RULE11
      end
   end

   assign o_fault_status = fault_latch;

   always_comb begin
      next_tx_word = fault_latch;
      unique case (read_page)
         PAGE_FAULTS: next_tx_word = fault_latch;
         PAGE_MASKS:  next_tx_word = mask_all;
         PAGE_CONFIG: next_tx_word = {1'b0, mode, dead_time};
         PAGE_BOOT:   next_tx_word = {{(CMD_W-PHASES){1'b0}}, boot_ready};
      endcase
   end

   // frozen while a frame runs so the link domain reads a steady word
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_word <= '0;
      end else if (sync_q[S_CS_N]) begin
         tx_word <= next_tx_word; // see RULE17
      end
   end

   assign en_sync   = sync_q[S_EN1] & sync_q[S_EN2]; // see RULE1
   assign dt_off    = mode[MODE_DT_OFF_BIT];
   assign ilk_off   = mode[MODE_ILK_OFF_BIT];
   assign req_high  = ~sync_q[S_HIGH_N +: PHASES]; // see RULE7
   assign req_low   = sync_q[S_LOW +: PHASES]; // see RULE8
   assign dead_load = DT_CNT_W'(DT_CNT_W'(dead_time) * DT_STEP_CYC);

   for (genvar p = 0; p < PHASES; p++) begin : g_phase
      logic                want_high;
      logic                want_low;
      logic                next_high_on;
      logic                next_low_on;
      logic                gap_done;
      logic [DT_CNT_W-1:0] dead_cnt;

      always_comb begin
         want_high    = req_high[p] & ~(req_low[p] & ~ilk_off);
         want_low     = req_low[p] & ~(req_high[p] & ~ilk_off);
         gap_done     = (dead_cnt == '0) | dt_off;
         next_high_on = en_sync & want_high &
                        (high_on[p] |
                         ((~low_on[p] | ilk_off) & gap_done));
         next_low_on  = en_sync & want_low &
                        (low_on[p] |
                         ((~high_on[p] | ilk_off) & gap_done));
      end

      // either driver switching off restarts the blanking gap
      always_ff @(posedge i_sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            dead_cnt <= '0;
         end else if ((high_on[p] & ~next_high_on) |
                      (low_on[p] & ~next_low_on)) begin
            dead_cnt <= dead_load; // see RULE16
         end else if (dead_cnt != '0) begin
            dead_cnt <= dead_cnt - 1'b1;
         end
      end

      always_ff @(posedge i_sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            high_on[p] <= 1'b0;
            low_on[p]  <= 1'b0;
         end else begin
            high_on[p] <= next_high_on; // see RULE16 see RULE2
            low_on[p]  <= next_low_on;
         end
      end

      // status only: the host owns the bootstrap order, nothing blocks here
      always_ff @(posedge i_sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            boot_ready[p] <= 1'b0;
         end else if (!en_sync) begin
            boot_ready[p] <= 1'b0; // see RULE4
         end else if (low_on[p]) begin
            boot_ready[p] <= 1'b1;
         end
      end

      always_ff @(posedge i_sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            level_q[p] <= 1'b0; // see RULE5
         end else begin
            level_q[p] <= sync_q[S_ABOVE + p]; // see RULE9
         end
      end
   end

   assign o_phase_a_high_gate = high_on[0] & drive_allowed; // see RULE2
   assign o_phase_b_high_gate = high_on[1] & drive_allowed; // see RULE2
   assign o_phase_c_high_gate = high_on[2] & drive_allowed; // see RULE2
   assign o_phase_a_low_gate  = low_on[0] & drive_allowed; // see RULE2
   assign o_phase_b_low_gate  = low_on[1] & drive_allowed; // see RULE2
   assign o_phase_c_low_gate  = low_on[2] & drive_allowed; // see RULE2

   // below power-on threshold the gate pins float rather than pull
   assign o_gate_oe        = i_por_n; // see RULE15
   assign o_gate_weak_pull = ~i_nrst & i_por_n; // see RULE5

   assign o_phase_a_level_out = level_q[0]; // see RULE9
   assign o_phase_b_level_out = level_q[1]; // see RULE9
   assign o_phase_c_level_out = level_q[2]; // see RULE9

endmodule // tppd_predriver_top
`default_nettype wire

//--- tppd_predriver_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tppd_predriver_properties
   import tppd_pkg::*;
(
   input wire logic               i_sys_clk,
   input wire logic               i_nrst,
   input wire logic               i_por_n,
   input wire logic               i_drive_enable_first,
   input wire logic               i_drive_enable_second,
   input wire logic               i_phase_a_high_cmd_n,
   input wire logic               i_phase_a_low_cmd,
   input wire logic               i_phase_a_above_half,
   input wire logic [FAULT_W-1:0] i_fault_event,
   input wire logic               i_spi_cs_n,
   input wire logic               o_phase_a_high_gate,
   input wire logic               o_phase_a_low_gate,
   input wire logic               o_gate_oe,
   input wire logic               o_gate_weak_pull,
   input wire logic               o_phase_a_level_out,
   input wire logic               o_fault_irq,
   input wire logic [FAULT_W-1:0] o_fault_status,
   input wire logic               o_spi_sdo_oe
);
   logic [3:0] since_fault;

   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst || !i_por_n);

   // cycles since any fault, so an interrupt needs a recent cause
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) since_fault <= 4'hf;
      else if (|i_fault_event) since_fault <= 4'h0;
      else if (since_fault != 4'hf) since_fault <= since_fault + 4'h1;
   end

   // 8 idle cycles: no serial command can still be in flight
   sequence s_cs_idle;
      i_spi_cs_n [*8];
   endsequence

   a_enable_gates_off: assert property ((!i_drive_enable_first ||
      !i_drive_enable_second) |-> !o_phase_a_high_gate && !o_phase_a_low_gate)
      else $error("gate on with an enable low");
   a_reset_quiet: assert property (disable iff (1'b0)
      (!i_nrst && i_por_n) |-> !o_phase_a_high_gate && !o_phase_a_low_gate
      && !o_fault_irq && o_gate_weak_pull && !o_spi_sdo_oe)
      else $error("outputs active in reset");
   a_por_float: assert property (disable iff (1'b0)
      o_gate_oe == i_por_n) else $error("gate enable not tied to por");
   a_sdo_float: assert property (i_spi_cs_n [*2] |-> !o_spi_sdo_oe)
      else $error("serial out driven while deselected");
   a_irq_held: assert property (s_cs_idle ##0 o_fault_irq |=> o_fault_irq)
      else $error("interrupt dropped without clear");
   a_irq_cause: assert property ($rose(o_fault_irq) |-> since_fault <= 4'h6)
      else $error("interrupt without recent fault");
   a_status_sticky: assert property (s_cs_idle |=>
      (o_fault_status & $past(o_fault_status)) == $past(o_fault_status))
      else $error("fault latch lost a bit");
   a_level_delay: assert property (
      o_phase_a_level_out == $past(i_phase_a_above_half, 3))
      else $error("phase level wrong");
   a_low_gate_cause: assert property ($rose(o_phase_a_low_gate) |->
      $past(i_phase_a_low_cmd, 3)) else $error("low gate without command");
   a_high_gate_cause: assert property ($rose(o_phase_a_high_gate) |->
      !$past(i_phase_a_high_cmd_n, 3)) else $error("high gate without command");
endmodule // tppd_predriver_properties

bind tppd_predriver_top tppd_predriver_properties u_props (.*);
`default_nettype wire

//--- tppd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tppd_host_model (
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_sdi,
   input  wire logic i_sdo,
   input  wire logic i_sdo_oe
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sdi  = 1'b0;
   end

   // odd start offset keeps link edges off the system grid
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      #7.1 o_cs_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #12 o_sdi = tx[i];
         #12 o_sclk = 1'b1;
         #24 o_sclk = 1'b0;
         rx[i] = i_sdo_oe ? i_sdo : 1'b0;
      end
      #30 o_cs_n = 1'b1;
      o_sdi = 1'b0;
      #40;
   endtask
endmodule // tppd_host_model
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       i_sys_clk = 1'b0;
   logic       i_nrst, i_por_n, i_spi_sclk, i_spi_cs_n, i_spi_sdi;
   logic       i_drive_enable_first, i_drive_enable_second;
   logic       i_phase_a_high_cmd_n, i_phase_b_high_cmd_n;
   logic       i_phase_c_high_cmd_n, i_phase_a_low_cmd;
   logic       i_phase_b_low_cmd, i_phase_c_low_cmd;
   logic       i_phase_a_above_half, i_phase_b_above_half;
   logic       i_phase_c_above_half, o_phase_c_level_out;
   logic       o_phase_a_high_gate, o_phase_b_high_gate;
   logic       o_phase_c_high_gate, o_phase_a_low_gate;
   logic       o_phase_b_low_gate, o_phase_c_low_gate;
   logic       o_gate_oe, o_gate_weak_pull, o_fault_irq;
   logic       o_spi_sdo, o_spi_sdo_oe;
   logic       o_phase_a_level_out, o_phase_b_level_out;
   logic [7:0] i_fault_event, o_fault_status, rx;
   int         fail_count = 0;
   int         n_tests = 0;
   int         cyc = 0;
   // rows: enables, high_n, low, above, want high, want low, want level
   logic [19:0] rows [6] = '{20'hff239, 20'hc0dc6, 20'h80402,
                              20'h40804, 20'hf3010, 20'h38e07};
   wire logic [5:0] gates = {o_phase_c_high_gate, o_phase_b_high_gate,
      o_phase_a_high_gate, o_phase_c_low_gate, o_phase_b_low_gate,
      o_phase_a_low_gate};
   wire logic [2:0] lvl = {o_phase_c_level_out, o_phase_b_level_out,
      o_phase_a_level_out};

   tppd_predriver_top uut (.*);
   tppd_host_model host (.o_sclk(i_spi_sclk), .o_cs_n(i_spi_cs_n),
      .o_sdi(i_spi_sdi), .i_sdo(o_spi_sdo), .i_sdo_oe(o_spi_sdo_oe));

   always #2 i_sys_clk = ~i_sys_clk;

   task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t value %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t flag %b want %b", $time, got, exp);
      end
   endtask

   task automatic apply(input logic [19:0] r);
      {i_drive_enable_first, i_drive_enable_second} <= r[19:18];
      {i_phase_c_high_cmd_n, i_phase_b_high_cmd_n,
         i_phase_a_high_cmd_n} <= r[17:15];
      {i_phase_c_low_cmd, i_phase_b_low_cmd, i_phase_a_low_cmd} <= r[14:12];
      {i_phase_c_above_half, i_phase_b_above_half,
         i_phase_a_above_half} <= r[11:9];
   endtask

   // long wait covers sync, the reset dead time and its gap
   task automatic do_row(input logic [19:0] r);
      @(posedge i_sys_clk);
      apply(r);
      repeat (100) @(posedge i_sys_clk);
      #1;
      chk_vec({2'h0, gates}, {2'h0, r[8:3]});
      chk_vec({5'h0, lvl}, {5'h0, r[2:0]});
   endtask

   // two cycles wide, then time for sync and interrupt logic
   task automatic pulse(input logic [7:0] f);
      @(posedge i_sys_clk);
      i_fault_event <= f;
      repeat (2) @(posedge i_sys_clk);
      i_fault_event <= 8'h00;
      repeat (10) @(posedge i_sys_clk);
      #1;
   endtask

   task automatic finish_test;
      $display("checks %0d failures %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end

   initial begin
      i_nrst <= 1'b0;
      i_por_n <= 1'b1;
      i_fault_event <= 8'h00;
      apply(20'h38000);
      repeat (11) @(posedge i_sys_clk);
      #1;
      chk_flag(o_gate_weak_pull, 1'b1);
      chk_vec({2'h0, gates}, 8'h00);
      @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      pulse(8'h00);
      chk_vec(o_fault_status, 8'h00);
      foreach (rows[i]) do_row(rows[i]);
      do_row(20'hff239);
      do_row(20'hc0dc6);
      @(posedge i_sys_clk);
      i_drive_enable_second <= 1'b0;
      #1;
      chk_vec({2'h0, gates}, 8'h00);
      host.xfer(8'h63, rx);
      do_row(20'hf1048);
      host.xfer(8'h21, rx);
      pulse(8'h01);
      chk_flag(o_fault_irq, 1'b0);
      pulse(8'h10);
      pulse(8'h00);
      chk_flag(o_fault_irq, 1'b1);
      chk_vec(o_fault_status & 8'h10, 8'h10);
      host.xfer(8'ha0, rx);
      pulse(8'h00);
      chk_flag(o_fault_irq, 1'b0);
      host.xfer(8'h4f, rx);
      pulse(8'h80);
      chk_flag(o_fault_irq, 1'b0);
      host.xfer(8'h01, rx);
      host.xfer(8'h00, rx);
      chk_vec(rx, 8'hf1);
      host.xfer(8'h88, rx);
      host.xfer(8'h02, rx);
      host.xfer(8'h00, rx);
      chk_vec(rx, 8'h68);
      host.xfer(8'h03, rx);
      host.xfer(8'h00, rx);
      chk_vec(rx, 8'h01);
      pulse(8'h04);
      @(posedge i_sys_clk);
      i_nrst <= 1'b0;
      #2;
      chk_vec({1'b0, o_fault_irq, gates}, 8'h00);
      repeat (12) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      pulse(8'h01);
      chk_flag(o_fault_irq, 1'b1);
      @(posedge i_sys_clk);
      i_por_n <= 1'b0;
      #1;
      chk_flag(o_gate_oe, 1'b0);
      host.xfer(8'h2f, rx);
      @(posedge i_sys_clk);
      i_por_n <= 1'b1;
      pulse(8'h01);
      chk_flag(o_fault_irq, 1'b1);
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
